// *** design/mbr_ctrl.sv ***
// Button debounce, wheel, resolution cycling and shortcut key logic
`timescale 1ns/1ps
`include "mbr_defines.svh"
module mbr_ctrl
    import mbr_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = `MBR_SAMPLE_CYCLES
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Variant strap
    input wire logic long_press_variant,
    // Button pins, low while pressed
    input wire logic left_button_input_n,
    input wire logic right_button_input_n,
    input wire logic middle_button_input_n,
    input wire logic back_button_input_n,
    input wire logic forward_button_input_n,
    input wire logic tilt_left_input_n,
    input wire logic tilt_right_input_n,
    // Wheel encoder counts
    input wire logic wheel_step,
    input wire logic wheel_up,
    // Report path
    input wire logic poll_req,
    output logic report_valid,
    output logic [7:0] report_buttons,
    output logic [7:0] report_wheel,
    output logic [7:0] report_hscroll,
    // Shortcut key output
    output logic key_valid,
    output logic [7:0] key_modifier,
    output logic [7:0] key_code,
    // Resolution state
    output logic [1:0] res_select,
    output logic indicator_first,
    output logic indicator_second,
    output logic indicator_third,
    // Debounced events
    output logic [`MBR_NBTN-1:0] button_state,
    output logic [`MBR_NBTN-1:0] button_press,
    output logic [`MBR_NBTN-1:0] button_release,
    // Configuration byte access
    input wire logic cfg_wr_en,
    input wire logic cfg_rd_en,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata
);

    mbr_state_t s_r;
    mbr_state_t s_nxt;

    logic [`MBR_NBTN-1:0] pins_n;
    logic cycle_en;
    logic short_en;
    logic tilt_en;
    logic cyc_idx_tilt;
    logic click;
    logic btn_a;
    logic btn_b;

    assign pins_n = {tilt_right_input_n, tilt_left_input_n,
                     forward_button_input_n, back_button_input_n,
                     middle_button_input_n, right_button_input_n,
                     left_button_input_n};

    assign cycle_en = s_r.devcfg[`MBR_F_CYCLE_HI]
                    ^ s_r.devcfg[`MBR_F_CYCLE_LO];
    assign short_en = s_r.devcfg[`MBR_F_SHORT_HI]
                    ^ s_r.devcfg[`MBR_F_SHORT_LO];
    assign tilt_en = !s_r.tilt[`MBR_F_TILT_DIS];
    // Tilt pins take over cycling and shortcut duty when tilt is off
    assign cyc_idx_tilt = !tilt_en;
    assign btn_a = cyc_idx_tilt ? s_r.db[`MBR_B_TILT_R]
                                : s_r.db[`MBR_B_FWD];
    assign btn_b = cyc_idx_tilt ? s_r.db[`MBR_B_TILT_L]
                                : s_r.db[`MBR_B_BACK];

    always_comb begin
        logic [1:0] cnt;
        logic [7:0] half;
        logic cyc_press;
        logic cyc_release;
        logic [`MBR_NBTN-1:0] rep_mask;
        cnt = 2'h0;
        half = 8'h00;
        rep_mask = '0;
        s_nxt = s_r;
        cyc_press = cyc_idx_tilt ? s_r.press[`MBR_B_TILT_R]
                                 : s_r.press[`MBR_B_FWD];
        cyc_release = cyc_idx_tilt ? s_r.release_ev[`MBR_B_TILT_R]
                                   : s_r.release_ev[`MBR_B_FWD];

        // Pin synchronisers
        s_nxt.sync1 = pins_n;
        s_nxt.sync2 = s_r.sync1;

        // Sample tick
        s_nxt.tick = 1'b0;
        if (s_r.tick_cnt == `MBR_TICK_W'(SAMPLE_CYCLES - 1)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + `MBR_TICK_W'(1);
        end

        // Debounce per button
        s_nxt.press = '0;
        s_nxt.release_ev = '0;
        if (s_r.tick) begin
            for (int i = 0; i < `MBR_NBTN; i++) begin
                cnt = s_r.agree[2*i +: 2];
                if ((!s_r.sync2[i]) == s_r.db[i]) begin
                    cnt = 2'h0;
                end else begin
                    cnt = cnt + 2'h1;
                end
                if (cnt == `MBR_AGREE_NEEDED) begin
                    s_nxt.db[i] = !s_r.db[i];
                    s_nxt.press[i] = !s_r.db[i];
                    s_nxt.release_ev[i] = s_r.db[i];
                    cnt = 2'h0;
                end
                s_nxt.agree[2*i +: 2] = cnt;
            end
        end

        // Hold time of the cycling button, in sample ticks
        if (cyc_press) begin
            s_nxt.hold_cnt = 8'h00;
        end else if (s_r.tick && btn_a &&
                     s_r.hold_cnt != `MBR_HOLD_MAX) begin
            s_nxt.hold_cnt = s_r.hold_cnt + 8'h01;
        end

        click = long_press_variant
              ? (cyc_release && s_r.hold_cnt >= s_r.hold)
              : cyc_press;

        // Resolution state
        if (!cycle_en) begin
            s_nxt.res = MBR_RES_FIRST;
        end else if (click) begin
            case (s_r.res)
                MBR_RES_FIRST: s_nxt.res = MBR_RES_SECOND;
                MBR_RES_SECOND: s_nxt.res = MBR_RES_THIRD;
                MBR_RES_THIRD: s_nxt.res = MBR_RES_FIRST;
                default: s_nxt.res = MBR_RES_FIRST;
            endcase
        end
        case (s_nxt.res)
            MBR_RES_FIRST: s_nxt.ind = 3'b001;
            MBR_RES_SECOND: s_nxt.ind = 3'b010;
            MBR_RES_THIRD: s_nxt.ind = 3'b100;
            default: s_nxt.ind = 3'b001;
        endcase

        // Shortcut key codes
        if (short_en && btn_a) begin
            s_nxt.key_valid = 1'b1;
            s_nxt.key_mod = s_r.mod_a;
            s_nxt.key_code = s_r.key_a;
        end else if (short_en && btn_b) begin
            s_nxt.key_valid = 1'b1;
            s_nxt.key_mod = s_r.mod_b;
            s_nxt.key_code = s_r.key_b;
        end else begin
            s_nxt.key_valid = 1'b0;
            s_nxt.key_mod = 8'h00;
            s_nxt.key_code = 8'h00;
        end

        // Buttons carrying cycling or shortcut duty are kept out
        if (cycle_en || short_en) begin
            rep_mask[cyc_idx_tilt ? `MBR_B_TILT_R : `MBR_B_FWD] = 1'b1;
        end
        if (short_en) begin
            rep_mask[cyc_idx_tilt ? `MBR_B_TILT_L : `MBR_B_BACK] = 1'b1;
        end

        // Poll: report half of the wheel count and consume twice the reported value
        s_nxt.rep_valid = 1'b0;
        if (poll_req) begin
            half = 8'($signed(s_r.wheel_acc) >>> 1);
            s_nxt.rep_valid = 1'b1;
            s_nxt.rep_wheel = half;
            s_nxt.wheel_acc = s_r.wheel_acc - {half[6:0], 1'b0};
            s_nxt.rep_buttons = {3'b000,
                                 s_r.db[`MBR_B_FWD:`MBR_B_LEFT]
                                 & ~rep_mask[`MBR_B_FWD:`MBR_B_LEFT]};
            s_nxt.rep_hscroll = 8'h00;
            if (tilt_en && s_r.db[`MBR_B_TILT_L]) begin
                s_nxt.rep_hscroll = `MBR_HSCROLL_LEFT;
            end else if (tilt_en && s_r.db[`MBR_B_TILT_R]) begin
                s_nxt.rep_hscroll = `MBR_HSCROLL_RIGHT;
            end
        end
        if (wheel_step) begin
            s_nxt.wheel_acc = wheel_up ? s_nxt.wheel_acc + 8'h01
                                       : s_nxt.wheel_acc - 8'h01;
        end

        // Configuration bytes
        if (cfg_wr_en) begin
            case (cfg_addr)
                `MBR_A_DEVCFG: s_nxt.devcfg = cfg_wdata;
                `MBR_A_MOD_A: s_nxt.mod_a = cfg_wdata;
                `MBR_A_MOD_B: s_nxt.mod_b = cfg_wdata;
                `MBR_A_KEY_A: s_nxt.key_a = cfg_wdata;
                `MBR_A_KEY_B: s_nxt.key_b = cfg_wdata;
                `MBR_A_HOLD: s_nxt.hold = cfg_wdata;
                `MBR_A_TILT: s_nxt.tilt = cfg_wdata;
                default: s_nxt.devcfg = s_r.devcfg;
            endcase
        end
        if (cfg_rd_en) begin
            case (cfg_addr)
                `MBR_A_DEVCFG: s_nxt.cfg_rdata = s_r.devcfg;
                `MBR_A_MOD_A: s_nxt.cfg_rdata = s_r.mod_a;
                `MBR_A_MOD_B: s_nxt.cfg_rdata = s_r.mod_b;
                `MBR_A_KEY_A: s_nxt.cfg_rdata = s_r.key_a;
                `MBR_A_KEY_B: s_nxt.cfg_rdata = s_r.key_b;
                `MBR_A_HOLD: s_nxt.cfg_rdata = s_r.hold;
                `MBR_A_TILT: s_nxt.cfg_rdata = s_r.tilt;
                default: s_nxt.cfg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s_r <= '0;
            s_r.sync1 <= '1;
            s_r.sync2 <= '1;
            s_r.res <= MBR_RES_FIRST;
            s_r.ind <= 3'b001;
            s_r.devcfg <= `MBR_RST_BYTE;
            s_r.hold <= `MBR_RST_HOLD;
            s_r.tilt <= `MBR_RST_BYTE;
        end else if (clock_enable) begin
            s_r <= s_nxt;
        end
    end

    assign report_valid = s_r.rep_valid;
    assign report_buttons = s_r.rep_buttons;
    assign report_wheel = s_r.rep_wheel;
    assign report_hscroll = s_r.rep_hscroll;
    assign key_valid = s_r.key_valid;
    assign key_modifier = s_r.key_mod;
    assign key_code = s_r.key_code;
    assign res_select = s_r.res;
    assign indicator_first = s_r.ind[0];
    assign indicator_second = s_r.ind[1];
    assign indicator_third = s_r.ind[2];
    assign button_state = s_r.db;
    assign button_press = s_r.press;
    assign button_release = s_r.release_ev;
    assign cfg_rdata = s_r.cfg_rdata;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset || !clock_enable);

    sequence seq_tick;
        s_r.tick;
    endsequence

    sequence seq_flip;
        $changed(s_r.db[`MBR_B_LEFT]) && !$past(reset);
    endsequence

    chk_tick_period: assert property (
        seq_tick |-> $past(s_r.tick_cnt) ==
            `MBR_TICK_W'(SAMPLE_CYCLES - 1))
        else $error("sample tick off period");

    chk_press_event: assert property (
        s_r.press[`MBR_B_LEFT] |-> s_r.db[`MBR_B_LEFT] &&
            !$past(s_r.db[`MBR_B_LEFT]) && $past(s_r.tick) &&
            !$past(s_r.sync2[`MBR_B_LEFT]) &&
            $past(s_r.agree[1:0]) == 2'h2)
        else $error("press without three low samples");

    chk_release_event: assert property (
        s_r.release_ev[`MBR_B_LEFT] |-> !s_r.db[`MBR_B_LEFT] &&
            $past(s_r.db[`MBR_B_LEFT]) && $past(s_r.tick) &&
            $past(s_r.sync2[`MBR_B_LEFT]) &&
            $past(s_r.agree[1:0]) == 2'h2)
        else $error("release without three high samples");

    chk_flip_needs_run: assert property (
        seq_flip |-> $past(s_r.tick) && $past(s_r.agree[1:0]) == 2'h2)
        else $error("debounced state flipped early");

    chk_fixed_first: assert property (
        !cycle_en |=> s_r.res == MBR_RES_FIRST)
        else $error("resolution not fixed at first");

    chk_cycle_order: assert property (
        $changed(s_r.res) && $past(cycle_en) && !$past(reset) |->
            (s_r.res == MBR_RES_SECOND && $past(s_r.res) == MBR_RES_FIRST)
         || (s_r.res == MBR_RES_THIRD && $past(s_r.res) == MBR_RES_SECOND)
         || (s_r.res == MBR_RES_FIRST && $past(s_r.res) == MBR_RES_THIRD))
        else $error("resolution stepped out of order");

    chk_indicator_onehot: assert property (
        s_r.ind == (3'b001 << s_r.res))
        else $error("indicators not matching state");

    chk_wheel_half: assert property (
        s_r.rep_valid |->
            s_r.rep_wheel == 8'($signed($past(s_r.wheel_acc)) >>> 1))
        else $error("wheel report not halved");

    chk_shortcut_code: assert property (
        $past(short_en) && $past(btn_a) && !$past(reset) |->
            s_r.key_valid && s_r.key_mod == $past(s_r.mod_a) &&
            s_r.key_code == $past(s_r.key_a))
        else $error("wrong shortcut code sent");

    chk_tilt_off: assert property (
        s_r.rep_valid && !$past(tilt_en) |-> s_r.rep_hscroll == 8'h00)
        else $error("tilt reported while disabled");

endmodule

// *** design/mbr_defines.svh ***
// Constants for the button and resolution controller
`ifndef MBR_DEFINES_SVH
`define MBR_DEFINES_SVH

// Timing
`define MBR_CLK_NS 50
`define MBR_SAMPLE_US 2000
`define MBR_SAMPLE_CYCLES (`MBR_SAMPLE_US * 1000 / `MBR_CLK_NS)
`define MBR_AGREE_NEEDED 2'h3
`define MBR_TICK_W 16

// Button indices in the sampled vector
`define MBR_NBTN 7
`define MBR_B_LEFT 0
`define MBR_B_RIGHT 1
`define MBR_B_MIDDLE 2
`define MBR_B_BACK 3
`define MBR_B_FWD 4
`define MBR_B_TILT_L 5
`define MBR_B_TILT_R 6

// Configuration byte addresses
`define MBR_A_DEVCFG 8'hC1
`define MBR_A_MOD_A 8'hC2
`define MBR_A_MOD_B 8'hC3
`define MBR_A_KEY_A 8'hC4
`define MBR_A_KEY_B 8'hC5
`define MBR_A_HOLD 8'hC6
`define MBR_A_TILT 8'hC7

// Field positions
`define MBR_F_CYCLE_HI 3
`define MBR_F_CYCLE_LO 2
`define MBR_F_SHORT_HI 1
`define MBR_F_SHORT_LO 0
`define MBR_F_TILT_DIS 0

// Reset values, hold limit and scroll codes
`define MBR_RST_BYTE 8'h00
`define MBR_RST_HOLD 8'h80
`define MBR_HOLD_MAX 8'hFF
`define MBR_HSCROLL_LEFT 8'hFF
`define MBR_HSCROLL_RIGHT 8'h01

`endif

// *** design/mbr_pkg.sv ***
// Types for the button and resolution controller
`include "mbr_defines.svh"
package mbr_pkg;

    typedef enum logic [1:0] {
        MBR_RES_FIRST = 2'b00,
        MBR_RES_SECOND = 2'b01,
        MBR_RES_THIRD = 2'b10
    } mbr_res_t;

    typedef struct packed {
        logic [`MBR_TICK_W-1:0] tick_cnt;
        logic tick;
        logic [`MBR_NBTN-1:0] sync1;
        logic [`MBR_NBTN-1:0] sync2;
        logic [`MBR_NBTN-1:0] db;
        logic [2*`MBR_NBTN-1:0] agree;
        logic [`MBR_NBTN-1:0] press;
        logic [`MBR_NBTN-1:0] release_ev;
        logic [7:0] devcfg;
        logic [7:0] mod_a;
        logic [7:0] mod_b;
        logic [7:0] key_a;
        logic [7:0] key_b;
        logic [7:0] hold;
        logic [7:0] tilt;
        logic [7:0] hold_cnt;
        mbr_res_t res;
        logic [2:0] ind;
        logic [7:0] wheel_acc;
        logic [7:0] rep_buttons;
        logic [7:0] rep_wheel;
        logic [7:0] rep_hscroll;
        logic rep_valid;
        logic [7:0] key_mod;
        logic [7:0] key_code;
        logic key_valid;
        logic [7:0] cfg_rdata;
    } mbr_state_t;

endpackage

// *** testbench/mbr_mech_model.sv ***
// Mechanical buttons, tilt switches and wheel encoder model
`timescale 1ns/1ps
module mbr_mech_model (
    // Clock
    input wire logic clock,
    // Commands from the bench
    input wire logic [6:0] hold,
    input wire logic spin,
    input wire logic dir,
    // Switch pins, pulled up while open
    output logic [6:0] pin_n,
    // Encoder counts
    output logic wheel_step = 1'b0,
    output logic wheel_up = 1'b0
);
    logic phase_r = 1'b0;
    assign pin_n = ~hold;
    // One count every other clock while spinning
    always_ff @(posedge clock) begin
        phase_r <= ~phase_r;
        wheel_step <= spin & phase_r;
        wheel_up <= spin ? dir : ~wheel_up;
    end
endmodule

// *** testbench/mouse_button_resolution_ctrl_test.sv ***
// Self-checking bench for the button and resolution controller
`timescale 1ns/1ps
module mouse_button_resolution_ctrl_test;
    import mbr_pkg::*;
    localparam int SC = 8;
    localparam int DB = 5 * SC + 6;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic lp = 1'b0, spin = 1'b0, dir = 1'b0, poll = 1'b0;
    logic we = 1'b0, re = 1'b0, wstep, wup, rv, kv, i0, i1, i2;
    logic [6:0] hold = '0, pin_n, bs, bp, br, sp = '0, sr = '0;
    logic [7:0] addr = '0, wd = '0, rdat, rb, rw, rh, km, kc, d;
    logic [7:0] rnd = 8'h58, ma, ka, mb, kb;
    logic [1:0] rs, er;
    int bad_count = 0, samples_checked = 0, n;
    bit en;

    always #25 clock = ~clock;

    always @(posedge clock) begin
        sp <= sp | bp;
        sr <= sr | br;
    end

    mbr_mech_model i_mech (.clock(clock), .hold(hold), .spin(spin),
        .dir(dir), .pin_n(pin_n), .wheel_step(wstep), .wheel_up(wup));

    mbr_ctrl #(.SAMPLE_CYCLES(SC)) i_dut (.clock(clock), .reset(reset),
        .clock_enable(1'b1), .long_press_variant(lp),
        .left_button_input_n(pin_n[0]), .right_button_input_n(pin_n[1]),
        .middle_button_input_n(pin_n[2]), .back_button_input_n(pin_n[3]),
        .forward_button_input_n(pin_n[4]), .tilt_left_input_n(pin_n[5]),
        .tilt_right_input_n(pin_n[6]), .wheel_step(wstep),
        .wheel_up(wup), .poll_req(poll), .report_valid(rv),
        .report_buttons(rb), .report_wheel(rw), .report_hscroll(rh),
        .key_valid(kv), .key_modifier(km), .key_code(kc),
        .res_select(rs), .indicator_first(i0), .indicator_second(i1),
        .indicator_third(i2), .button_state(bs), .button_press(bp),
        .button_release(br), .cfg_wr_en(we), .cfg_rd_en(re),
        .cfg_addr(addr), .cfg_wdata(wd), .cfg_rdata(rdat));

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic [2:0] onehot(input logic [1:0] r);
        return 3'b001 << r;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int c);
        repeat (c) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        wd = v;
        we = 1'b1;
        wt(1);
        we = 1'b0;
        wt(1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        addr = a;
        re = 1'b1;
        wt(1);
        re = 1'b0;
        v = rdat;
        wt(1);
    endtask

    task automatic poll_chk(input logic [7:0] b, w, h);
        poll = 1'b1;
        wt(1);
        poll = 1'b0;
        chk(8'(rv), 8'h01);
        chk(rb, b);
        chk(rw, w);
        chk(rh, h);
        wt(1);
        chk(8'(rv), 8'h00);
    endtask

    task automatic click(input int b, input int ticks);
        hold[b] = 1'b1;
        wt(DB + ticks * SC);
        hold[b] = 1'b0;
        wt(DB);
    endtask

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 60000);
        bad_count++;
        end_of_test;
    end

    initial begin
        wt(20);
        reset = 1'b0;
        chk(8'(rs), 8'h00);
        chk(8'({i2, i1, i0}), 8'(onehot(2'b00)));
        wr(8'hC8, 8'hFF);
        for (int a = 8'hC0; a < 8'hC9; a++) begin
            rd(8'(a), d);
            chk(d, a == 8'hC6 ? 8'h80 : 8'h00);
        end
        for (int a = 8'hC1; a < 8'hC8; a++) begin
            rnd = lfsr(rnd);
            wr(8'(a), rnd);
            rd(8'(a), d);
            chk(d, rnd);
            wr(8'(a), 8'h00);
        end
        // Each button and tilt through press and release
        for (int i = 0; i < 7; i++) begin
            sp = '0;
            sr = '0;
            hold[i] = 1'b1;
            wt(2 * SC);
            chk(8'(bs[i]), 8'h00);
            wt(DB - 2 * SC);
            chk(8'(bs[i] & sp[i]), 8'h01);
            poll_chk(i < 5 ? 8'h01 << i : 8'h00, 8'h00,
                i == 5 ? 8'hFF : (i == 6 ? 8'h01 : 8'h00));
            hold[i] = 1'b0;
            wt(2 * SC);
            chk(8'(bs[i]), 8'h01);
            wt(DB - 2 * SC);
            chk(8'(bs[i]), 8'h00);
            chk(8'(sr[i]), 8'h01);
        end
        sp = '0;
        hold[0] = 1'b1;
        wt(SC + 4);
        hold[0] = 1'b0;
        wt(DB);
        chk(8'(bs[0] | sp[0]), 8'h00);
        wr(8'hC7, 8'h01);
        hold[5] = 1'b1;
        wt(DB);
        poll_chk(8'h00, 8'h00, 8'h00);
        hold[5] = 1'b0;
        wr(8'hC7, 8'h00);
        wt(DB);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            n = 2 * (int'(rnd[1:0]) + 1);
            dir = rnd[7];
            spin = 1'b1;
            wt(2 * n);
            spin = 1'b0;
            wt(2);
            poll_chk(8'h00, dir ? 8'(n / 2) : 8'(-n / 2), 8'h00);
        end
        // Cycling field codes, clicks on the forward button
        er = 2'b00;
        for (int f = 0; f < 4; f++) begin
            en = (f == 1 || f == 2);
            wr(8'hC1, 8'(f << 2));
            if (!en) er = 2'b00;
            chk(8'(rs), 8'(er));
            for (int k = 0; k <= f; k++) begin
                click(4, 0);
                if (en) er = (er == 2'b10) ? 2'b00 : er + 2'b01;
                chk(8'(rs), 8'(er));
                chk(8'({i2, i1, i0}), 8'(onehot(er)));
            end
        end
        reset = 1'b1;
        wt(2);
        reset = 1'b0;
        chk(8'(rs), 8'h00);
        rd(8'hC6, d);
        chk(d, 8'h80);
        // Long press variant: short click ignored, long one counts
        lp = 1'b1;
        wr(8'hC6, 8'h10);
        wr(8'hC1, 8'h04);
        click(4, 0);
        chk(8'(rs), 8'h00);
        click(4, 20);
        chk(8'(rs), 8'h01);
        lp = 1'b0;
        rnd = lfsr(rnd);
        ma = rnd;
        ka = lfsr(rnd);
        mb = lfsr(ka);
        kb = lfsr(mb);
        rnd = kb;
        wr(8'hC2, ma);
        wr(8'hC4, ka);
        wr(8'hC3, mb);
        wr(8'hC5, kb);
        for (int f = 0; f < 4; f++) begin
            en = (f == 1 || f == 2);
            wr(8'hC1, 8'(f));
            for (int s = 0; s < 2; s++) begin
                hold[s ? 3 : 4] = 1'b1;
                wt(DB);
                chk(8'(kv), 8'(en));
                chk(km, en ? (s ? mb : ma) : 8'h00);
                chk(kc, en ? (s ? kb : ka) : 8'h00);
                poll_chk(en ? 8'h00 : (s ? 8'h08 : 8'h10), 8'h00, 8'h00);
                hold[s ? 3 : 4] = 1'b0;
                wt(DB);
                chk(8'(kv), 8'h00);
            end
        end
        end_of_test;
    end
endmodule
